// File: verif/stg_dma_model.sv
/* dma side stand-in: host-to-card source and card-to-host sink
   assumes the bench hands whole packets to send */
`timescale 1ns/1ps
`default_nettype none
module stg_dma_model (
  input wire logic clk_in,
  input wire logic h2c_tready_in,
  output logic [63:0] h2c_tdata_out,
  output logic [7:0] h2c_tkeep_out,
  output logic h2c_tlast_out,
  output logic h2c_tvalid_out,
  input wire logic [63:0] c2h_tdata_in,
  input wire logic [7:0] c2h_tkeep_in,
  input wire logic c2h_tlast_in,
  input wire logic c2h_tvalid_in,
  output logic c2h_tready_out
);
  logic stall = 1'b0;
  // set when a beat waited out its bound; the bench turns it into a failure
  logic hung = 1'b0;
  logic [72:0] got[$];
  initial begin
    {h2c_tlast_out, h2c_tkeep_out, h2c_tdata_out} = 73'h0;
    h2c_tvalid_out = 1'b0;
    c2h_tready_out = 1'b1;
  end
  // stalling every other cycle makes the block hold its output
  always @(posedge clk_in) begin
    c2h_tready_out <= !stall | !c2h_tready_out;
    if (c2h_tvalid_in && c2h_tready_out) begin
      got.push_back({c2h_tlast_in, c2h_tkeep_in, c2h_tdata_in});
    end
  end
  task automatic send(input logic [72:0] bs[$]);
    int w;
    foreach (bs[i]) begin
      {h2c_tlast_out, h2c_tkeep_out, h2c_tdata_out} <= bs[i];
      h2c_tvalid_out <= 1'b1;
      @(posedge clk_in);
      for (w = 0; w < 64 && !h2c_tready_in; w++) @(posedge clk_in);
      if (w == 64) hung = 1'b1;
    end
    h2c_tvalid_out <= 1'b0;
    // released data lines do not keep the last beat
    h2c_tdata_out <= ~h2c_tdata_out;
  endtask
endmodule // stg_dma_model
`default_nettype wire

// File: verif/stg_traffic_assertions.sv
/* checker for stg_traffic: bus, stream and mismatch timing
   assumes only the top module's ports, bound below */
`timescale 1ns/1ps
`default_nettype none
module stg_traffic_assertions (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic link_up_in,
  input wire logic dma_soft_rst_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic avs_waitrequest_out,
  input wire logic [63:0] h2c_tdata_in,
  input wire logic h2c_tlast_in,
  input wire logic h2c_tvalid_in,
  input wire logic h2c_tready_out,
  input wire logic [63:0] c2h_tdata_out,
  input wire logic c2h_tlast_out,
  input wire logic c2h_tvalid_out,
  input wire logic c2h_tready_in,
  input wire logic mismatch_out
);
  logic [2:0] ctl_q;
  logic fire_q;
  wire lk = link_up_in & ~dma_soft_rst_in;
  // shadow of the control bits, updated on the bus taking edge
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctl_q <= 3'h0;
      fire_q <= 1'b0;
    end else begin
      if (avs_write_in && !avs_waitrequest_out && avs_address_in == 5'h00
          && avs_byteenable_in[0]) begin
        ctl_q <= avs_writedata_in[2:0];
      end
      fire_q <= ctl_q[1] & ~ctl_q[2] & h2c_tvalid_in & h2c_tready_out;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  bus_wait_a: assert property (
    $rose(avs_read_in | avs_write_in) |->
    avs_waitrequest_out ##1 !avs_waitrequest_out) else $error("bus wait");
  c2h_hold_a: assert property (disable iff (sys_rst_in || !lk)
    c2h_tvalid_out && !c2h_tready_in |=> c2h_tvalid_out &&
    $stable(c2h_tdata_out) && $stable(c2h_tlast_out)) else $error("c2h hold");
  loop_echo_a: assert property (disable iff (sys_rst_in || !lk)
    ctl_q[2] && h2c_tvalid_in && h2c_tready_out |=> c2h_tvalid_out &&
    c2h_tdata_out == $past(h2c_tdata_in) &&
    c2h_tlast_out == $past(h2c_tlast_in)) else $error("loop echo");
  loop_quiet_a: assert property (
    ctl_q[2] && !mismatch_out |=> !mismatch_out) else $error("loop flag");
  chk_off_a: assert property (
    !ctl_q[1] |=> !mismatch_out) else $error("checker off flag");
  engine_clear_a: assert property (
    !lk |=> !c2h_tvalid_out && !mismatch_out) else $error("engine clear");
  gen_start_a: assert property (
    $rose(ctl_q[0]) && !ctl_q[2] && lk && !c2h_tvalid_out
    |=> c2h_tvalid_out)
    else $error("gen start");
  mis_cause_a: assert property (
    $rose(mismatch_out) |-> fire_q) else $error("flag without beat");
endmodule // stg_traffic_assertions
bind stg_traffic stg_traffic_assertions stg_traffic_assertions_inst (
  .clk_sys_in(clk_sys_in),
  .sys_rst_in(sys_rst_in),
  .link_up_in(link_up_in),
  .dma_soft_rst_in(dma_soft_rst_in),
  .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in),
  .avs_waitrequest_out(avs_waitrequest_out),
  .h2c_tdata_in(h2c_tdata_in),
  .h2c_tlast_in(h2c_tlast_in),
  .h2c_tvalid_in(h2c_tvalid_in),
  .h2c_tready_out(h2c_tready_out),
  .c2h_tdata_out(c2h_tdata_out),
  .c2h_tlast_out(c2h_tlast_out),
  .c2h_tvalid_out(c2h_tvalid_out),
  .c2h_tready_in(c2h_tready_in),
  .mismatch_out(mismatch_out)
);
`default_nettype wire

// File: verif/stg_traffic_test.sv
/* bench for stg_traffic: registers, generator, checker, loopback
   assumes stg_dma_model as the dma engine */
`timescale 1ns/1ps
`default_nettype none
module stg_traffic_test;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic link_up_in = 1'b1;
  logic dma_soft_rst_in = 1'b0;
  logic [4:0] avs_address_in = 5'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] rdat;
  wire [31:0] avs_readdata_out;
  wire avs_waitrequest_out, h2c_tlast_in, h2c_tvalid_in, h2c_tready_out;
  wire [63:0] h2c_tdata_in, c2h_tdata_out;
  wire [7:0] h2c_tkeep_in, c2h_tkeep_out;
  wire c2h_tlast_out, c2h_tvalid_out, c2h_tready_in, mismatch_out;
  int errors = 0;
  int n_checks = 0;
  always #25 clk_sys_in = ~clk_sys_in;
  stg_traffic stg_traffic_inst (.*);
  stg_dma_model stg_dma_model_inst (.clk_in(clk_sys_in),
    .h2c_tready_in(h2c_tready_out), .h2c_tdata_out(h2c_tdata_in),
    .h2c_tkeep_out(h2c_tkeep_in), .h2c_tlast_out(h2c_tlast_in),
    .h2c_tvalid_out(h2c_tvalid_in), .c2h_tdata_in(c2h_tdata_out),
    .c2h_tkeep_in(c2h_tkeep_out), .c2h_tlast_in(c2h_tlast_out),
    .c2h_tvalid_in(c2h_tvalid_out), .c2h_tready_out(c2h_tready_in));
  task summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [72:0] s, input logic [72:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("Error %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    avs_address_in <= a; // any byte offset in the 5-bit window
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    @(posedge clk_sys_in);
    for (n = 0; n < 16 && avs_waitrequest_out !== 1'b0; n++)
      @(posedge clk_sys_in);
    if (n == 16) begin
      errors++;
      summarize;
    end
    rdat = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  // hand a packet to the dma model; a stuck beat ends the run
  task push(input logic [72:0] q[$]);
    stg_dma_model_inst.send(q);
    if (stg_dma_model_inst.hung) begin
      errors++;
      summarize;
    end
  endtask
  // one beat: length in the low lanes of beat 0, tag in all others
  function automatic logic [72:0] pat(input logic [15:0] len, tag, int i);
    int nb;
    logic [7:0] k;
    nb = (len + 7) / 8;
    if (nb == 0) nb = 1;
    k = (i == nb - 1 && len[2:0] != 0) ? 8'hFF >> (8 - len[2:0]) : 8'hFF;
    return {i == nb - 1, k, {3{tag}}, i == 0 ? len : tag};
  endfunction
  task t_regs;
    bus(0, 5'h04, 0);
    chk(rdat, 32'h40);
    bus(0, 5'h08, 0);
    chk(rdat, 32'hFFFF);
    bus(1, 5'h14, 32'hFFFFFFFF);
    bus(0, 5'h14, 0);
    chk(rdat, 0);
    bus(1, 5'h0C, 32'h1);
    bus(0, 5'h0C, 0);
    chk(rdat, 32'h4);
    $display("t_regs done");
  endtask
  task t_gen;
    int i, n;
    stg_dma_model_inst.stall <= 1'b1;
    bus(1, 5'h04, 10);
    bus(1, 5'h08, 1);
    bus(1, 5'h00, 1);
    for (n = 0; n < 200 && stg_dma_model_inst.got.size() < 6; n++)
      @(posedge clk_sys_in);
    if (n == 200) begin
      errors++;
      summarize;
    end
    bus(1, 5'h00, 0);
    for (i = 0; i < 6; i++)
      chk(stg_dma_model_inst.got[i], pat(10, i / 2 % 2, i % 2));
    link_up_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    link_up_in <= 1'b1;
    @(posedge clk_sys_in);
    bus(0, 5'h10, 0);
    chk(rdat, 0);
    stg_dma_model_inst.got.delete();
    $display("t_gen done");
  endtask
  task t_chk;
    logic [72:0] q[$];
    int p, i;
    bus(1, 5'h00, 2);
    bus(0, 5'h00, 0);
    chk(rdat, 32'h2);
    for (p = 0; p < 3; p++) begin
      q.delete();
      for (i = 0; i < 2; i++) q.push_back(pat(10, p % 2, i));
      if (p == 2) q[1][8] = ~q[1][8];
      push(q);
      repeat (2) @(posedge clk_sys_in);
      chk(mismatch_out, p == 2);
    end
    bus(0, 5'h0C, 0);
    chk(rdat, 32'h5);
    dma_soft_rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    dma_soft_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    chk(mismatch_out, 0);
    $display("t_chk done");
  endtask
  task t_loop;
    logic [72:0] q[$];
    int i;
    bus(1, 5'h00, 7);
    for (i = 0; i < 2; i++) q.push_back(pat(10, 5, i));
    push(q);
    repeat (8) @(posedge clk_sys_in);
    chk(stg_dma_model_inst.got.size(), 2);
    for (i = 0; i < 2; i++) chk(stg_dma_model_inst.got[i], q[i]);
    chk(mismatch_out, 0);
    bus(1, 5'h00, 0);
    $display("t_loop done");
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    t_regs;
    t_gen;
    t_chk;
    t_loop;
    summarize;
  end
endmodule // stg_traffic_test
`default_nettype wire

// File: verilog/stg_map.vh
/*
  Register map, field positions, reset values and stream geometry of the
  stream traffic generator and checker.
  Assumes a 32-bit register bus with byte addresses and a 64-bit stream.
*/
`ifndef STG_MAP_VH
`define STG_MAP_VH

// register byte offsets (address bits [4:0])
`define STG_OFS_CONTROL 5'h00
`define STG_OFS_FRAME_LEN 5'h04
`define STG_OFS_TAG_WRAP 5'h08
`define STG_OFS_STATUS 5'h0C
`define STG_OFS_TAG_NOW 5'h10

// control register fields
`define STG_CTL_GEN_EN 0
`define STG_CTL_CHK_EN 1
`define STG_CTL_LOOP_EN 2

// status register fields
`define STG_STS_MISMATCH 0
`define STG_STS_GEN_BUSY 1
`define STG_STS_LINK_OK 2

// reset values
`define STG_RST_CONTROL 3'h0
`define STG_RST_FRAME_LEN 16'h0040
`define STG_RST_TAG_WRAP 16'hFFFF

// stream geometry: 8 bytes per beat
`define STG_DATA_W 64
`define STG_KEEP_W 8
`define STG_BEAT_SHIFT 3

`endif

// File: verilog/stg_pattern.v
/*
  Expected beat builder: the length-and-tag word pattern for one beat.
  Assumes little-endian byte lanes; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "stg_map.vh"

module stg_pattern (
  input wire first_in,
  input wire [15:0] len_in,
  input wire [15:0] tag_in,
  output wire [`STG_DATA_W-1:0] data_out
);

  // every 16-bit lane holds the tag
  // except the low lane of a first beat, which holds the length
  assign data_out = {tag_in, tag_in, tag_in, first_in ? len_in : tag_in};

endmodule // stg_pattern

`default_nettype wire

// File: verilog/stg_traffic.v
/*
  Stream traffic generator, checker and loopback with its register slave.
  Assumes one clock shared with the DMA stream channels, link status and
  soft reset; registers reached over Avalon-MM with waitrequest.
*/
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
// Functional notes
// - generator emits packets of programmed length
// - checker receives packets of programmed length
// - loopback returns every host beat to card-to-host
// - looped traffic is never compared
// - generator and checker start only when enabled
// - first beat low two bytes hold length
// - all other bytes hold packet tag
// - tag increments by one per packet
// - tag restarts after programmed wrap value
// - checker compares every kept byte from first beat
// - mismatch flag visible in status register
// - generated packets go to card-to-host channel
// - generator uses the checker's pattern
// - streams use valid/ready handshake
// - packet length comes from software register
// - registers sit behind a bus slave
// - link down or soft reset clears engines
`timescale 1ns/1ps
`default_nettype none
`include "stg_map.vh"

module stg_traffic (
  input wire clk_sys_in,
  input wire sys_rst_in,
  input wire link_up_in,
  input wire dma_soft_rst_in,
  input wire [4:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  input wire [`STG_DATA_W-1:0] h2c_tdata_in,
  input wire [`STG_KEEP_W-1:0] h2c_tkeep_in,
  input wire h2c_tlast_in,
  input wire h2c_tvalid_in,
  output wire h2c_tready_out,
  output wire [`STG_DATA_W-1:0] c2h_tdata_out,
  output wire [`STG_KEEP_W-1:0] c2h_tkeep_out,
  output wire c2h_tlast_out,
  output wire c2h_tvalid_out,
  input wire c2h_tready_in,
  output wire mismatch_out
);

  // beats in a packet of len bytes; a zero length still sends one beat
  function [13:0] num_beats;
    input [15:0] len;
    reg [13:0] n;
    begin
      n = {1'b0, len[15:`STG_BEAT_SHIFT]} + {13'h0000, |len[2:0]};
      num_beats = (n == 14'h0000) ? 14'h0001 : n;
    end
  endfunction

  // byte enables of the closing beat
  function [`STG_KEEP_W-1:0] tail_keep;
    input [15:0] len;
    begin
      case (len[2:0])
        3'h1: tail_keep = 8'h01;
        3'h2: tail_keep = 8'h03;
        3'h3: tail_keep = 8'h07;
        3'h4: tail_keep = 8'h0F;
        3'h5: tail_keep = 8'h1F;
        3'h6: tail_keep = 8'h3F;
        3'h7: tail_keep = 8'h7F;
        default: tail_keep = 8'hFF;
      endcase
    end
  endfunction

  function [15:0] next_tag;
    input [15:0] tag;
    input [15:0] wrap;
    begin
      if (tag == wrap) begin
        next_tag = 16'h0000;
      end else begin
        next_tag = tag + 16'h0001;
      end
    end
  endfunction

  function [31:0] merge_be;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    integer i;
    begin
      merge_be = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge_be[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  reg [2:0] control_q;
  reg [15:0] frame_len_q;
  reg [15:0] tag_wrap_q;
  reg bus_ack_q;
  reg mismatch_q;
  reg [13:0] gen_beat_q;
  reg [15:0] gen_tag_q;
  reg gen_busy_q;
  reg [13:0] chk_beat_q;
  reg [15:0] chk_tag_q;
  reg out_valid_q;
  reg [`STG_DATA_W-1:0] out_data_q;
  reg [`STG_KEEP_W-1:0] out_keep_q;
  reg out_last_q;

  wire gen_en = control_q[`STG_CTL_GEN_EN];
  wire chk_en = control_q[`STG_CTL_CHK_EN];
  wire loop_en = control_q[`STG_CTL_LOOP_EN];

  // engines are held clear while the link is down or the DMA resets them
  wire eng_clr = ~link_up_in | dma_soft_rst_in;

  wire [13:0] beats = num_beats(frame_len_q);
  wire [`STG_KEEP_W-1:0] last_keep = tail_keep(frame_len_q);

  // register slave: one wait cycle, then the access completes
  wire bus_req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = bus_req & ~bus_ack_q;
  wire bus_take = bus_req & bus_ack_q;

  wire [31:0] control_word = {29'h00000000, control_q};
  wire [31:0] len_word = {16'h0000, frame_len_q};
  wire [31:0] wrap_word = {16'h0000, tag_wrap_q};
  wire [31:0] status_word = {29'h00000000, link_up_in & ~dma_soft_rst_in,
                             gen_busy_q, mismatch_q};
  wire [31:0] tag_word = {chk_tag_q, gen_tag_q};

  reg [31:0] rd_mux;
  always @* begin
    case (avs_address_in)
      `STG_OFS_CONTROL: rd_mux = control_word;
      `STG_OFS_FRAME_LEN: rd_mux = len_word;
      `STG_OFS_TAG_WRAP: rd_mux = wrap_word;
      `STG_OFS_STATUS: rd_mux = status_word;
      `STG_OFS_TAG_NOW: rd_mux = tag_word;
      default: rd_mux = 32'h00000000;
    endcase
  end

  wire [31:0] control_wr = merge_be(control_word, avs_writedata_in,
                                    avs_byteenable_in);
  wire [31:0] len_wr = merge_be(len_word, avs_writedata_in,
                                avs_byteenable_in);
  wire [31:0] wrap_wr = merge_be(wrap_word, avs_writedata_in,
                                 avs_byteenable_in);

  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_ack_q <= 1'b0;
      avs_readdata_out <= 32'h00000000;
      control_q <= `STG_RST_CONTROL;
      frame_len_q <= `STG_RST_FRAME_LEN;
      tag_wrap_q <= `STG_RST_TAG_WRAP;
    end else begin
      bus_ack_q <= bus_req & ~bus_ack_q;
      // read data is captured during the wait cycle and held after
      if (avs_read_in & ~bus_ack_q) begin
        avs_readdata_out <= rd_mux;
      end
      if (bus_take & avs_write_in) begin
        case (avs_address_in)
          `STG_OFS_CONTROL: control_q <= control_wr[2:0];
          `STG_OFS_FRAME_LEN: frame_len_q <= len_wr[15:0];
          `STG_OFS_TAG_WRAP: tag_wrap_q <= wrap_wr[15:0];
          default: control_q <= control_q;
        endcase
      end
    end
  end

  // card-to-host output stage; loopback takes it before the generator
  wire stage_free = ~out_valid_q | c2h_tready_in;
  wire loop_act = loop_en & ~eng_clr;
  assign h2c_tready_out = ~loop_act | stage_free;
  wire h2c_fire = h2c_tvalid_in & h2c_tready_out;
  wire loop_load = loop_act & h2c_fire;
  // a started packet is finished even if the enable drops meanwhile
  wire gen_load = stage_free & ~loop_en & ~eng_clr
                  & (gen_busy_q | gen_en);
  wire gen_last = (gen_beat_q == beats - 14'h0001);

  wire [`STG_DATA_W-1:0] gen_data;
  wire [`STG_DATA_W-1:0] chk_data;

  // the same builder serves both directions, so they cannot disagree
  stg_pattern u_gen_pattern (
    .first_in(gen_beat_q == 14'h0000),
    .len_in(frame_len_q),
    .tag_in(gen_tag_q),
    .data_out(gen_data)
  );

  stg_pattern u_chk_pattern (
    .first_in(chk_beat_q == 14'h0000),
    .len_in(frame_len_q),
    .tag_in(chk_tag_q),
    .data_out(chk_data)
  );

  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_valid_q <= 1'b0;
      out_data_q <= {`STG_DATA_W{1'b0}};
      out_keep_q <= {`STG_KEEP_W{1'b0}};
      out_last_q <= 1'b0;
      gen_beat_q <= 14'h0000;
      gen_tag_q <= 16'h0000;
      gen_busy_q <= 1'b0;
    end else if (eng_clr) begin
      out_valid_q <= 1'b0;
      gen_beat_q <= 14'h0000;
      gen_tag_q <= 16'h0000;
      gen_busy_q <= 1'b0;
    end else begin
      if (loop_load) begin
        out_valid_q <= 1'b1;
        out_data_q <= h2c_tdata_in;
        out_keep_q <= h2c_tkeep_in;
        out_last_q <= h2c_tlast_in;
      end else if (gen_load) begin
        out_valid_q <= 1'b1;
        out_data_q <= gen_data;
        out_keep_q <= gen_last ? last_keep : 8'hFF;
        out_last_q <= gen_last;
        if (gen_last) begin
          gen_beat_q <= 14'h0000;
          gen_tag_q <= next_tag(gen_tag_q, tag_wrap_q);
          gen_busy_q <= 1'b0;
        end else begin
          gen_beat_q <= gen_beat_q + 14'h0001;
          gen_busy_q <= 1'b1;
        end
      end else if (c2h_tready_in) begin
        out_valid_q <= 1'b0;
      end
    end
  end

  assign c2h_tvalid_out = out_valid_q;
  assign c2h_tdata_out = out_data_q;
  assign c2h_tkeep_out = out_keep_q;
  assign c2h_tlast_out = out_last_q;

  // checker: only kept bytes are compared; a misplaced end also fails
  wire chk_act = chk_en & ~loop_en & ~eng_clr;
  wire chk_fire = chk_act & h2c_fire;
  wire chk_end = (chk_beat_q == beats - 14'h0001);
  reg [`STG_DATA_W-1:0] keep_mask;
  integer b;
  always @* begin
    keep_mask = {`STG_DATA_W{1'b0}};
    for (b = 0; b < `STG_KEEP_W; b = b + 1) begin
      keep_mask[b*8 +: 8] = {8{h2c_tkeep_in[b]}};
    end
  end
  wire byte_bad = |((h2c_tdata_in ^ chk_data) & keep_mask);
  wire chk_bad = byte_bad | (h2c_tlast_in != chk_end);

  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      chk_beat_q <= 14'h0000;
      chk_tag_q <= 16'h0000;
      mismatch_q <= 1'b0;
    end else if (eng_clr | ~chk_en) begin
      chk_beat_q <= 14'h0000;
      chk_tag_q <= 16'h0000;
      mismatch_q <= 1'b0;
    end else begin
      if (chk_fire & chk_bad) begin
        mismatch_q <= 1'b1;
      end
      if (chk_fire) begin
        // resynchronise on the sender's end marker, not the count
        if (h2c_tlast_in) begin
          chk_beat_q <= 14'h0000;
          chk_tag_q <= next_tag(chk_tag_q, tag_wrap_q);
        end else begin
          chk_beat_q <= chk_beat_q + 14'h0001;
        end
      end
    end
  end

  assign mismatch_out = mismatch_q;

endmodule // stg_traffic

`default_nettype wire
